// ---- hw/stm_pkg.sv ----
// Package of constants and carrier types for the standard timer mode and period block.
package stm_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_MODE_CTL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD   = 8'h04;
    localparam logic [7:0] ADDR_RUN_CTL  = 8'h08;
    localparam logic [7:0] ADDR_A_CMP    = 8'h0c;
    localparam logic [7:0] ADDR_COUNT    = 8'h10;
    localparam logic [7:0] ADDR_CAPTURE  = 8'h14;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  RST_MODE_CTL = 8'h00;
    localparam logic [7:0]  RST_PERIOD   = 8'h00;
    localparam logic [15:0] RST_WORD16   = 16'h0000;
    localparam logic [31:0] RST_WORD32   = 32'h0000_0000;

    // ************************************************************
    // Field positions of timer_mode_control and the run register
    // ************************************************************
    localparam int MODE_HI  = 7;
    localparam int MODE_LO  = 6;
    localparam int PF_HI    = 5;
    localparam int PF_LO    = 4;
    localparam int OC_BIT   = 3;
    localparam int POL_BIT  = 2;
    localparam int DPX_BIT  = 1;
    localparam int CCLR_BIT = 0;
    localparam int RUN_BIT  = 0;

    // ************************************************************
    // Mode and pin function encodings
    // ************************************************************
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;
    localparam logic [1:0] PF_0     = 2'h0;
    localparam logic [1:0] PF_1     = 2'h1;
    localparam logic [1:0] PF_2     = 2'h2;
    localparam logic [1:0] PF_3     = 2'h3;

    localparam logic [7:0]  LOW_BYTE_ZERO = 8'h00;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } stm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } stm_apb_rsp_t;

    typedef struct packed {
        logic [7:0]  mode_ctl;
        logic [7:0]  period;
        logic        run;
        logic [15:0] a_cmp;
        logic [15:0] count;
        logic        cmp_level;
        logic        cap_prev;
        logic [15:0] cap_val;
        logic        cap_evt;
        logic        pin_out;
        logic        pin_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } stm_state_t;

endpackage : stm_pkg

// ---- hw/stm_compare.sv ----
// Comparators A and P of the standard timer with the counter's next value.
`timescale 1ns/1ps
module stm_compare (
    input  wire logic [15:0] count,
    input  wire logic [15:0] a_cmp,
    input  wire logic [7:0]  period,
    output logic      [15:0] count_next,
    output logic             a_hit,
    output logic             p_hit,
    output logic             wrap,
    output logic             duty_a,
    output logic             duty_p
);
    // Matches look at the value the counter is about to take, so a clear lands
    // exactly on the period boundary and no extra count is spent.
    assign count_next = 16'(count + stm_pkg::COUNT_ONE);
    assign a_hit      = (count_next == a_cmp);
    assign p_hit      = (period != stm_pkg::RST_PERIOD) &&
                        (count_next[15:8] == period) &&
                        (count_next[7:0] == stm_pkg::LOW_BYTE_ZERO);
    assign wrap       = (count == stm_pkg::COUNT_MAX);
    assign duty_a     = (count < a_cmp);
    // A zero period value stands for a full 65536-count duty.
    assign duty_p     = (period == stm_pkg::RST_PERIOD) || (count[15:8] < period);
endmodule : stm_compare

// ---- hw/stm_timer.sv ----
// Standard timer mode, pin function and period compare logic with an APB slave.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module stm_timer (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire stm_pkg::stm_apb_req_t apb_req,
    output stm_pkg::stm_apb_rsp_t     apb_rsp,
    input  wire logic                 count_tick,
    input  wire logic                 capture_input_pin,
    output logic                      timer_output_pin,
    output logic                      timer_output_pin_oe,
    output logic                      capture_event
);

    // ************************************************************
    // State and comparators
    // ************************************************************
    stm_pkg::stm_state_t s_q;
    stm_pkg::stm_state_t s_d;

    logic [15:0] count_next;
    logic        a_hit;
    logic        p_hit;
    logic        wrap;
    logic        duty_a;
    logic        duty_p;

    stm_compare u_compare (
        .count      (s_q.count),
        .a_cmp      (s_q.a_cmp),
        .period     (s_q.period),
        .count_next (count_next),
        .a_hit      (a_hit),
        .p_hit      (p_hit),
        .wrap       (wrap),
        .duty_a     (duty_a),
        .duty_p     (duty_p)
    );

    logic [1:0] mode;
    logic [1:0] pf;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;
    logic       wr_go;
    logic       step;
    logic       cap_rise;
    logic       cap_fall;

    assign mode     = s_q.mode_ctl[stm_pkg::MODE_HI:stm_pkg::MODE_LO];
    assign pf       = s_q.mode_ctl[stm_pkg::PF_HI:stm_pkg::PF_LO];
    assign oc       = s_q.mode_ctl[stm_pkg::OC_BIT];
    assign pol      = s_q.mode_ctl[stm_pkg::POL_BIT];
    assign dpx      = s_q.mode_ctl[stm_pkg::DPX_BIT];
    assign cclr     = s_q.mode_ctl[stm_pkg::CCLR_BIT];
    // A write takes effect at the edge where the master sees pready high.
    assign wr_go    = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.pready;
    assign step     = s_q.run & count_tick;
    assign cap_rise = capture_input_pin & ~s_q.cap_prev;
    assign cap_fall = ~capture_input_pin & s_q.cap_prev;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic       mapped;
        logic [31:0] rd;
        logic       clr;
        logic       cap_hit;
        logic       lvl;
        logic       drive;
        logic       active;
        mapped  = 1'b1;
        rd      = stm_pkg::RST_WORD32;
        clr     = 1'b0;
        cap_hit = 1'b0;
        lvl     = 1'b0;
        drive   = 1'b0;
        active  = 1'b0;
        s_d     = s_q;

        // Register decode; read-only registers ignore writes without error.
        case (apb_req.paddr)
            stm_pkg::ADDR_MODE_CTL: rd = {24'h00_0000, s_q.mode_ctl};
            stm_pkg::ADDR_PERIOD:   rd = {24'h00_0000, s_q.period};
            stm_pkg::ADDR_RUN_CTL:  rd = {31'h0000_0000, s_q.run};
            stm_pkg::ADDR_A_CMP:    rd = {16'h0000, s_q.a_cmp};
            stm_pkg::ADDR_COUNT:    rd = {16'h0000, s_q.count};
            stm_pkg::ADDR_CAPTURE:  rd = {16'h0000, s_q.cap_val};
            default:                mapped = 1'b0;
        endcase

        // One wait state: pready rises in the second access cycle only.
        s_d.pready  = apb_req.psel & apb_req.penable & ~s_q.pready;
        s_d.prdata  = s_d.pready ? rd : stm_pkg::RST_WORD32;
        s_d.pslverr = s_d.pready & ~mapped;

        // Counter, clear sources and single pulse stop.
        if (step) begin
            case (mode)
                stm_pkg::MODE_CMP, stm_pkg::MODE_TMR: begin
                    clr = cclr ? a_hit : (p_hit | wrap);
                end
                stm_pkg::MODE_PWM: begin
                    if (pf == stm_pkg::PF_3) begin
                        // The pulse ends on an A match; the counter only stops.
                        if (a_hit) begin
                            s_d.run = 1'b0;
                        end
                    end else begin
                        clr = dpx ? a_hit : (p_hit | wrap);
                    end
                end
                default: clr = 1'b0;
            endcase
            s_d.count = clr ? stm_pkg::RST_WORD16 : count_next;
        end

        // Compare-mode pin level on an A match.
        if (step && (mode == stm_pkg::MODE_CMP) && a_hit) begin
            case (pf)
                stm_pkg::PF_1: s_d.cmp_level = 1'b0;
                stm_pkg::PF_2: s_d.cmp_level = 1'b1;
                stm_pkg::PF_3: s_d.cmp_level = ~s_q.cmp_level;
                default:       s_d.cmp_level = s_q.cmp_level;
            endcase
        end

        // Capture edge selection; capture only runs while the counter runs.
        case (pf)
            stm_pkg::PF_0: cap_hit = cap_rise;
            stm_pkg::PF_1: cap_hit = cap_fall;
            stm_pkg::PF_2: cap_hit = cap_rise | cap_fall;
            default:       cap_hit = 1'b0;
        endcase
        s_d.cap_evt  = (mode == stm_pkg::MODE_CAP) & s_q.run & cap_hit;
        s_d.cap_prev = capture_input_pin;
        if (s_d.cap_evt) begin
            s_d.cap_val = s_q.count;
        end

        // Software writes come last so they win over the pulse stop.
        if (wr_go) begin
            case (apb_req.paddr)
                stm_pkg::ADDR_MODE_CTL: s_d.mode_ctl = apb_req.pwdata[7:0];
                stm_pkg::ADDR_PERIOD:   s_d.period   = apb_req.pwdata[7:0];
                stm_pkg::ADDR_RUN_CTL:  s_d.run      = apb_req.pwdata[stm_pkg::RUN_BIT];
                stm_pkg::ADDR_A_CMP:    s_d.a_cmp    = apb_req.pwdata[15:0];
                default:                s_d.run      = s_d.run;
            endcase
        end

        // A run rising edge restarts from zero; a falling edge just stops counting.
        if (s_d.run && !s_q.run) begin
            s_d.count     = stm_pkg::RST_WORD16;
            s_d.cmp_level = oc;
        end

        // Output pin: the mode picks the level, polarity is applied last.
        active = dpx ? duty_p : duty_a;
        case (mode)
            stm_pkg::MODE_CMP: begin
                drive = 1'b1;
                lvl   = s_d.cmp_level;
            end
            stm_pkg::MODE_PWM: begin
                drive = 1'b1;
                case (pf)
                    stm_pkg::PF_0: lvl = ~oc;
                    stm_pkg::PF_1: lvl = oc;
                    stm_pkg::PF_2: lvl = active ? oc : ~oc;
                    default:       lvl = s_d.run ? oc : ~oc;
                endcase
            end
            default: begin
                // Capture uses the pin as an input; timer mode releases it.
                drive = 1'b0;
                lvl   = 1'b0;
            end
        endcase
        s_d.pin_oe  = drive;
        s_d.pin_out = drive & (lvl ^ pol);
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{mode_ctl: stm_pkg::RST_MODE_CTL, period: stm_pkg::RST_PERIOD,
                     run: 1'b0, a_cmp: stm_pkg::RST_WORD16,
                     count: stm_pkg::RST_WORD16, cmp_level: 1'b0, cap_prev: 1'b0,
                     cap_val: stm_pkg::RST_WORD16, cap_evt: 1'b0, pin_out: 1'b0,
                     pin_oe: 1'b0, prdata: stm_pkg::RST_WORD32, pready: 1'b0,
                     pslverr: 1'b0};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign apb_rsp             = '{prdata: s_q.prdata, pready: s_q.pready,
                                   pslverr: s_q.pslverr};
    assign timer_output_pin    = s_q.pin_out;
    assign timer_output_pin_oe = s_q.pin_oe;
    assign capture_event       = s_q.cap_evt;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    run_rise_clr_a: assert property ($rose(s_q.run) |-> s_q.count == 16'h0000)
        else $error("counter not zero after run rising edge");

    run_off_hold_a: assert property (!s_q.run && $past(!s_q.run) |-> $stable(s_q.count))
        else $error("counter moved while stopped");

    tmr_no_drive_a: assert property (clk_en && mode == stm_pkg::MODE_TMR
                                     |=> !timer_output_pin_oe && !timer_output_pin)
        else $error("pin driven in timer mode");

    init_level_a: assert property ($rose(s_q.run) && $past(clk_en)
                                   |-> s_q.cmp_level == $past(oc))
        else $error("initial level not restored");

    pol_last_a: assert property (clk_en && mode == stm_pkg::MODE_CMP
                                 |=> timer_output_pin == ($past(s_d.cmp_level) ^ $past(pol)))
        else $error("compare pin level or polarity wrong");

    pwm_force_a: assert property (clk_en && mode == stm_pkg::MODE_PWM
                                  && pf == stm_pkg::PF_0
                                  |=> timer_output_pin == (~$past(oc) ^ $past(pol)))
        else $error("forced inactive level wrong");

    pulse_stop_a: assert property (clk_en && step && mode == stm_pkg::MODE_PWM
                                   && pf == stm_pkg::PF_3 && a_hit && !wr_go
                                   |=> !s_q.run)
        else $error("single pulse did not stop on A match");

    p_clear_a: assert property (clk_en && step && mode == stm_pkg::MODE_CMP && !cclr
                                && (p_hit || wrap) && !wr_go |=> s_q.count == 16'h0000)
        else $error("no clear on period match or overflow");

    a_clear_a: assert property (clk_en && step && mode == stm_pkg::MODE_TMR && cclr
                                && a_hit && !wr_go |=> s_q.count == 16'h0000)
        else $error("no clear on A match");

    cmp_toggle_a: assert property (clk_en && step && mode == stm_pkg::MODE_CMP
                                   && pf == stm_pkg::PF_3 && a_hit && !wr_go
                                   |=> s_q.cmp_level != $past(s_q.cmp_level))
        else $error("compare toggle missing");

    cap_edge_a: assert property (clk_en && mode == stm_pkg::MODE_CAP && pf == stm_pkg::PF_0
                                 && s_q.run && cap_rise
                                 |=> capture_event && s_q.cap_val == $past(s_q.count))
        else $error("rising capture missed");

    apb_wait_a: assert property (clk_en && apb_req.psel && apb_req.penable && !s_q.pready
                                 |=> s_q.pready ##1 !s_q.pready || !clk_en)
        else $error("pready not a single pulse");

    cmp_drive_a: assert property (clk_en && mode == stm_pkg::MODE_CMP
        |=> timer_output_pin_oe)
        else $error("pin not driven in compare mode");

    cap_release_a: assert property (clk_en && mode == stm_pkg::MODE_CAP
        |=> !timer_output_pin_oe && !timer_output_pin)
        else $error("pin driven in capture mode");

    pwm_active_a: assert property (clk_en && mode == stm_pkg::MODE_PWM
        && pf == stm_pkg::PF_1
        |=> timer_output_pin == ($past(oc) ^ $past(pol)))
        else $error("forced active level wrong");

    pwm_duty_a: assert property (clk_en && mode == stm_pkg::MODE_PWM
        && pf == stm_pkg::PF_2 && !dpx
        |=> timer_output_pin == (($past(duty_a) == $past(oc)) ^ $past(pol)))
        else $error("pwm level from comparator A wrong");

    pwm_swap_a: assert property (clk_en && mode == stm_pkg::MODE_PWM
        && pf == stm_pkg::PF_2 && dpx
        |=> timer_output_pin == (($past(duty_p) == $past(oc)) ^ $past(pol)))
        else $error("pwm level from comparator P wrong");

    cap_free_a: assert property (clk_en && step && mode == stm_pkg::MODE_CAP
        |=> s_q.count == $past(count_next))
        else $error("counter cleared in capture mode");

    tmr_keep_a: assert property (clk_en && step && mode == stm_pkg::MODE_TMR && cclr
        && !a_hit |=> s_q.count == $past(count_next))
        else $error("counter cleared without A match");

    off_no_cap_a: assert property (clk_en && !s_q.run |=> !capture_event)
        else $error("capture while stopped");

    cap_off_a: assert property (clk_en && mode == stm_pkg::MODE_CAP && pf == stm_pkg::PF_3
        |=> !capture_event)
        else $error("capture while disabled");

    cap_fall_a: assert property (clk_en && mode == stm_pkg::MODE_CAP && pf == stm_pkg::PF_1
        && s_q.run && cap_fall
        |=> capture_event && s_q.cap_val == $past(s_q.count))
        else $error("falling capture missed");

    cap_both_a: assert property (clk_en && mode == stm_pkg::MODE_CAP && pf == stm_pkg::PF_2
        && s_q.run && (cap_rise || cap_fall) |=> capture_event)
        else $error("two-edge capture missed");

    en_freeze_a: assert property (!clk_en |=> $stable(s_q))
        else $error("state moved while clock enable low");

    cmp_high_a: assert property (clk_en && step && mode == stm_pkg::MODE_CMP
        && pf == stm_pkg::PF_2 && a_hit |=> s_q.cmp_level)
        else $error("compare high missing");

    cmp_low_a: assert property (clk_en && step && mode == stm_pkg::MODE_CMP
        && pf == stm_pkg::PF_1 && a_hit |=> !s_q.cmp_level)
        else $error("compare low missing");

    pwm_run_c: cover property (mode == stm_pkg::MODE_PWM && pf == stm_pkg::PF_2 && step);
    cmp_match_c: cover property (mode == stm_pkg::MODE_CMP && step && a_hit);
    capture_c: cover property (capture_event);
    pulse_end_c: cover property (mode == stm_pkg::MODE_PWM && pf == stm_pkg::PF_3 && a_hit);
    freeze_c: cover property (!clk_en && step);

endmodule : stm_timer

// ---- bench/stm_pin_partner.sv ----
// Model of the external timer pins: drives the capture input and resolves the output pin.
`timescale 1ns/1ps
module stm_pin_partner (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic cap_drive,
    output logic      capture_input_pin,
    input  wire logic timer_output_pin,
    input  wire logic timer_output_pin_oe,
    output logic      pin_level
);
    logic last_q;

    // The outside source changes its level only just after a clock edge.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_input_pin <= 1'b0;
            last_q            <= 1'b0;
        end else begin
            capture_input_pin <= cap_drive;
            if (timer_output_pin_oe) last_q <= timer_output_pin;
        end
    end

    // The pin has no pull, so a released pin shows the inverse of its last level.
    assign pin_level = timer_output_pin_oe ? timer_output_pin : ~last_q;
endmodule : stm_pin_partner

// ---- bench/tb_stm_timer.sv ----
// Self-checking testbench of the standard timer mode and period block.
`timescale 1ns/1ps
module tb_stm_timer;
    logic                  core_clk;
    logic                  reset_n;
    stm_pkg::stm_apb_req_t req;
    stm_pkg::stm_apb_rsp_t rsp;
    logic                  tick_q;
    logic                  en_q;
    logic                  cap_pin;
    logic                  cap_drive;
    logic                  out_pin;
    logic                  out_oe;
    logic                  cap_evt;
    logic                  pin;
    logic [31:0]           rd;
    logic                  err;
    logic [31:0]           rnd;
    int                    failures = 0;
    int                    num_checks = 0;
    int                    ev_cnt = 0;
    int                    n0;
    int                    m_count = 0;
    int                    m_run = 0;
    int                    m_mode = 0;
    int                    m_cclr = 0;
    int                    m_per = 0;
    int                    m_acmp = 0;

    stm_timer i_stm_timer (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .clk_en              (en_q),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .count_tick          (tick_q),
        .capture_input_pin   (cap_pin),
        .timer_output_pin    (out_pin),
        .timer_output_pin_oe (out_oe),
        .capture_event       (cap_evt)
    );

    stm_pin_partner i_stm_pin_partner (
        .core_clk            (core_clk),
        .reset_n             (reset_n),
        .cap_drive           (cap_drive),
        .capture_input_pin   (cap_pin),
        .timer_output_pin    (out_pin),
        .timer_output_pin_oe (out_oe),
        .pin_level           (pin)
    );

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (cap_evt === 1'b1) ev_cnt++;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            $display("BAD t=%0t no pready", $time);
            results();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (4) @(posedge core_clk);
    endtask : settle

    // The model counter follows the clear rules of compare and timer modes only.
    task automatic tick(input int n);
        @(posedge core_clk);
        tick_q <= 1'b1;
        repeat (n) @(posedge core_clk);
        tick_q <= 1'b0;
        for (int i = 0; i < n && m_run != 0; i++) begin
            m_count = (m_count + 1) % 65536;
            if (m_mode == 0 || m_mode == 3) begin
                if (m_cclr != 0 && m_count == m_acmp) m_count = 0;
                else if (m_cclr == 0 && m_per != 0 && m_count == m_per * 256) m_count = 0;
            end
        end
        settle();
    endtask : tick

    task automatic rd_count();
        apb(1'b0, stm_pkg::ADDR_COUNT, 32'h0);
        check(rd, m_count, "count");
    endtask : rd_count

    task automatic setup(input int md, pf, oc, pol, dpx, cc, per, ac);
        apb(1'b1, stm_pkg::ADDR_RUN_CTL, 32'h0);
        apb(1'b1, stm_pkg::ADDR_A_CMP, 32'(ac));
        apb(1'b1, stm_pkg::ADDR_PERIOD, 32'(per));
        apb(1'b1, stm_pkg::ADDR_MODE_CTL, {24'h0, md[1:0], pf[1:0], oc[0], pol[0], dpx[0], cc[0]});
        m_mode = md;
        m_cclr = cc;
        m_per = per;
        m_acmp = ac;
        apb(1'b1, stm_pkg::ADDR_RUN_CTL, 32'h1);
        m_run = 1;
        m_count = 0;
        settle();
    endtask : setup

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        req = '0;
        tick_q = 1'b0;
        en_q = 1'b1;
        cap_drive = 1'b0;
        void'($urandom(35));
        rnd = $urandom;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;

        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            check(rd, 32'h0, "reset value");
        end
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, stm_pkg::ADDR_PERIOD, rnd);
        apb(1'b0, stm_pkg::ADDR_PERIOD, 32'h0);
        check(rd, {24'h0, rnd[7:0]}, "period rw");
        apb(1'b1, stm_pkg::ADDR_MODE_CTL, rnd);
        apb(1'b0, stm_pkg::ADDR_MODE_CTL, 32'h0);
        check(rd, {24'h0, rnd[7:0]}, "mode rw");
        apb(1'b1, stm_pkg::ADDR_COUNT, rnd);
        rd_count();
        $display("register test ended");

        for (int pf = 0; pf < 4; pf++) begin
            for (int oc = 0; oc < 2; oc++) begin
                n0 = (pf % 2) ^ int'(rnd[0]);
                setup(0, pf, oc, n0, 0, 0, 2, 32'h104);
                check({31'h0, out_oe}, 32'h1, "cmp oe");
                check({31'h0, pin}, oc ^ n0, "initial level");
                tick(32'h104);
                check({31'h0, pin}, ((pf == 0) ? oc : (pf == 3) ? 1 - oc : pf - 1) ^ n0,
                      "match");
                rd_count();
                apb(1'b1, stm_pkg::ADDR_RUN_CTL, 32'h0);
                apb(1'b1, stm_pkg::ADDR_RUN_CTL, 32'h1);
                settle();
                check({31'h0, pin}, oc ^ n0, "restart level");
            end
        end
        $display("compare test ended");

        setup(3, int'(rnd[2:1]), 1, 1, 0, 1, 0, 10);
        check({30'h0, out_oe, out_pin}, 32'h0, "timer pin");
        tick(10);
        rd_count();
        tick(7);
        en_q <= 1'b0;
        m_run = 0;
        tick(4);
        en_q <= 1'b1;
        m_run = 1;
        rd_count();
        apb(1'b1, stm_pkg::ADDR_RUN_CTL, 32'h0);
        m_run = 0;
        tick(3);
        rd_count();
        setup(0, 0, 0, 0, 0, 0, 1, 32'h8000);
        tick(255);
        rd_count();
        tick(1);
        rd_count();
        setup(0, 0, 0, 0, 0, 0, 0, 32'h8000);
        tick(65535);
        rd_count();
        tick(1);
        rd_count();
        $display("counter test ended");

        for (int pf = 0; pf < 2; pf++) begin
            setup(2, pf, 1, int'(rnd[3]), 0, 0, 1, 3);
            check({31'h0, pin}, pf ^ int'(rnd[3]), "forced level");
        end
        setup(2, 2, 0, 0, 0, 0, 1, 3);
        check({31'h0, pin}, 32'h0, "pwm active low");
        tick(3);
        check({31'h0, pin}, 32'h1, "pwm duty end");
        setup(2, 2, 1, 0, 1, 0, 1, 32'h200);
        check({31'h0, pin}, 32'h1, "swap active");
        tick(256);
        check({31'h0, pin}, 32'h0, "swap duty end");
        setup(2, 3, 1, 1, 0, 0, 1, 5);
        check({31'h0, pin}, 32'h0, "pulse active");
        tick(5);
        check({31'h0, pin}, 32'h1, "pulse end");
        apb(1'b0, stm_pkg::ADDR_RUN_CTL, 32'h0);
        check(rd, 32'h0, "pulse run");
        $display("pwm test ended");

        for (int pf = 0; pf < 4; pf++) begin
            setup(1, pf, 0, 0, 0, 1, 0, 2);
            tick(5);
            check({31'h0, out_oe}, 32'h0, "capture oe");
            for (int e = 1; e >= 0; e--) begin
                n0 = ev_cnt;
                cap_drive <= e[0];
                settle();
                check(ev_cnt - n0, (pf == 2 || pf == 1 - e) ? 1 : 0, "capture");
                apb(1'b0, stm_pkg::ADDR_CAPTURE, 32'h0);
                if (pf == 2 || pf == 1 - e) check(rd, m_count, "captured");
            end
        end
        $display("capture test ended");
        results();
    end
endmodule : tb_stm_timer
